/* rtl/af_flag_pkg.sv */
// shared constants for the almost-full flag bus block
package af_flag_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 18;
  localparam int NUM_Q = 4;
  localparam int QSEL_W = 2;
  localparam int DEV_ID_W = 3;
  localparam int WADDR_W = 5;
  localparam int NQ_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DEPTH = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 8'h10;
  localparam int CFG_WMODE_LSB = 0;
  localparam int CFG_NQ_LSB = 4;
  localparam int ST_AF_LSB = 4;
  localparam int ST_FF_LSB = 5;
  localparam int ST_OWN_LSB = 6;
  localparam int ST_POLL_LSB = 7;
  localparam int ST_WQ_LSB = 8;
  localparam logic [CNT_W-1:0] OFFSET_DEF_LO = 18'h00008;
  localparam logic [CNT_W-1:0] OFFSET_DEF_HI = 18'h00080;
  localparam logic [CNT_W-1:0] DEPTH_RESET = 18'h04000;
  localparam logic [NQ_W-1:0] NQ_RESET = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WIDTH_EQUAL, WIDTH_IN18_OUT9, WIDTH_IN9_OUT18} width_mode_e;
endpackage : af_flag_pkg

/* rtl/strap_sync.sv */
// two-flop synchroniser for static strap and id pins
`timescale 1ns/1ps
module strap_sync
  import af_flag_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_s;

  sync_state_s r;
  sync_state_s next_r;

  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.sync = r.meta;
    if (!aresetn) begin
      next_r.meta = d;
      next_r.sync = r.meta;
    end
  end

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  assign q = r.sync;
endmodule : strap_sync

/* rtl/queue_level_tracker.sv */
// occupancy count and almost-full / full boundary for one queue
`timescale 1ns/1ps
module queue_level_tracker
  import af_flag_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wr,
  input  wire logic             rd,
  input  wire logic             rd_sel,
  input  width_mode_e           wmode,
  input  wire logic [CNT_W-1:0] depth,
  input  wire logic [CNT_W-1:0] offset,
  output logic                  raw,
  output logic                  af_set,
  output logic                  full_next,
  output logic      [CNT_W-1:0] level
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             half;
    logic             first_rd;
    logic             stage;
  } trk_state_s;

  trk_state_s r;
  trk_state_s next_r;
  logic [CNT_W-1:0] thr_af;
  logic [CNT_W-1:0] thr_ff;

  always_comb begin
    logic eq;
    logic narrow_in;
    logic extra_af;
    logic extra_ff;
    logic [CNT_W-1:0] base_af;
    logic [CNT_W-1:0] base_ff;
    logic [CNT_W-1:0] dec;
    logic [CNT_W-1:0] sum;
    eq = (wmode == WIDTH_EQUAL);
    narrow_in = (wmode == WIDTH_IN9_OUT18);
    // first word landing while read port sits on this queue goes to the output stage
    extra_af = narrow_in || (eq && r.first_rd);
    extra_ff = (eq || narrow_in) && r.first_rd;
    base_af = depth - offset + CNT_W'(extra_af);
    base_ff = depth + CNT_W'(extra_ff);
    thr_af = narrow_in ? (base_af << 1) : base_af;
    thr_ff = narrow_in ? (base_ff << 1) : base_ff;
    next_r = r;
    dec = '0;
    if (rd) begin
      if (eq) begin
        dec = CNT_W'(1);
      end else if (narrow_in) begin
        dec = CNT_W'(2);
      end else begin
        // two narrow reads drain one wide write
        dec = CNT_W'(r.half);
        next_r.half = !r.half;
      end
    end
    sum = r.count + CNT_W'(wr);
    next_r.count = (sum >= dec) ? (sum - dec) : '0;
    if (wr && r.count == '0) begin
      next_r.first_rd = rd_sel;
    end
    raw = (r.count >= thr_af);
    // extra stage makes assertion two edges late, release only one
    next_r.stage = raw;
    af_set = raw && r.stage;
    full_next = (next_r.count >= thr_ff);
    if (!aresetn) begin
      next_r = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  assign level = r.count;
endmodule : queue_level_tracker

/* rtl/almost_full_flag_bus.sv */
// write-side almost-full flags, shared flag bus control and register slave
`timescale 1ns/1ps
module almost_full_flag_bus
  import af_flag_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic      [1:0]          bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic      [31:0]         rdata,
  output logic      [1:0]          rresp,
  input  wire logic                write_enable,
  input  wire logic                write_queue_load,
  input  wire logic [WADDR_W-1:0]  write_address_bus,
  input  wire logic                flag_bus_select_strobe,
  input  wire logic                read_enable,
  input  wire logic [QSEL_W-1:0]   read_queue,
  input  wire logic [DEV_ID_W-1:0] device_number_inputs,
  input  wire logic                flag_bus_mode_select,
  input  wire logic                ring_master_select,
  input  wire logic                default_offset_select,
  input  wire logic                token_in,
  output logic                     almost_full_flag_n,
  output logic                     full_flag_n,
  output logic      [NUM_Q-1:0]    almost_full_status_bus_o,
  output logic                     almost_full_status_bus_oe,
  output logic                     flag_bus_sync_pulse,
  output logic                     token_out
);
  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                have_aw;
    logic                have_w;
    logic [ADDR_W-1:0]   waddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    width_mode_e         wmode;
    logic [NQ_W-1:0]     nq;
    logic [CNT_W-1:0]    depth;
    logic [CNT_W-1:0]    offset;
    logic                off_prog;
    logic                polled;
    logic                master;
    logic                df;
    logic [DEV_ID_W-1:0] dev_id;
    logic                started;
    logic                own;
    logic                sync_p;
    logic                tok_o;
    logic [NUM_Q-1:0]    status;
    logic                af_n;
    logic                ff_n;
    logic [QSEL_W-1:0]   wq;
  } top_state_s;

  top_state_s r;
  top_state_s next_r;

  logic [2:0]          straps_s;
  logic [DEV_ID_W-1:0] dev_id_s;
  logic [NUM_Q-1:0]    wr_q;
  logic [NUM_Q-1:0]    rd_q;
  logic [NUM_Q-1:0]    rd_sel_q;
  logic [NUM_Q-1:0]    raw_q;
  logic [NUM_Q-1:0]    af_set_q;
  logic [NUM_Q-1:0]    full_next_q;
  logic [CNT_W-1:0]    level_q [NUM_Q];
  logic [CNT_W-1:0]    off_eff;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CONFIG) || (a == ADDR_OFFSET) || (a == ADDR_DEPTH) ||
           (a == ADDR_STATUS) || (a == ADDR_LEVEL);
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // straps are static pins and settle before reset releases
  strap_sync #(.W(3)) u_strap_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({flag_bus_mode_select, ring_master_select, default_offset_select}),
    .q       (straps_s)
  );

  strap_sync #(.W(DEV_ID_W)) u_id_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (device_number_inputs),
    .q       (dev_id_s)
  );

  assign off_eff = r.off_prog ? r.offset : (r.df ? OFFSET_DEF_HI : OFFSET_DEF_LO);

  // every queue tracked at all times, selected or not
  for (genvar g = 0; g < NUM_Q; g++) begin : g_queue
    assign wr_q[g] = write_enable && (r.wq == QSEL_W'(g));
    assign rd_q[g] = read_enable && (read_queue == QSEL_W'(g));
    assign rd_sel_q[g] = (read_queue == QSEL_W'(g));
    queue_level_tracker u_trk (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .wr        (wr_q[g]),
      .rd        (rd_q[g]),
      .rd_sel    (rd_sel_q[g]),
      .wmode     (r.wmode),
      .depth     (r.depth),
      .offset    (off_eff),
      .raw       (raw_q[g]),
      .af_set    (af_set_q[g]),
      .full_next (full_next_q[g]),
      .level     (level_q[g])
    );
  end

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    wv = merge('0, r.wdata, r.wstrb);
    rv = '0;
    next_r = r;
    // write channel: address and data taken in either order
    if (awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.have_aw = 1'b1;
      next_r.waddr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.have_w = 1'b1;
      next_r.wdata = wdata;
      next_r.wstrb = wstrb;
    end
    if (r.have_aw && r.have_w && !r.bvalid) begin
      next_r.have_aw = 1'b0;
      next_r.have_w = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = is_mapped(r.waddr) ? RESP_OKAY : RESP_SLVERR;
      case (r.waddr)
        ADDR_CONFIG: begin
          wv = merge({25'h0, r.nq, 2'h0, r.wmode}, r.wdata, r.wstrb);
          next_r.wmode = (wv[CFG_WMODE_LSB +: 2] == 2'h3) ? WIDTH_EQUAL :
                         width_mode_e'(wv[CFG_WMODE_LSB +: 2]);
          next_r.nq = wv[CFG_NQ_LSB +: NQ_W];
        end
        ADDR_OFFSET: begin
          wv = merge({14'h0000, r.offset}, r.wdata, r.wstrb);
          next_r.offset = wv[CNT_W-1:0];
          next_r.off_prog = 1'b1;
        end
        ADDR_DEPTH: begin
          wv = merge({14'h0000, r.depth}, r.wdata, r.wstrb);
          next_r.depth = wv[CNT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end
    // read channel
    case (araddr)
      ADDR_CONFIG: rv[CFG_NQ_LSB +: NQ_W] = r.nq;
      ADDR_OFFSET: rv[CNT_W-1:0] = off_eff;
      ADDR_DEPTH:  rv[CNT_W-1:0] = r.depth;
      ADDR_STATUS: begin
        rv[NUM_Q-1:0] = r.status;
        rv[ST_AF_LSB] = r.af_n;
        rv[ST_FF_LSB] = r.ff_n;
        rv[ST_OWN_LSB] = r.own;
        rv[ST_POLL_LSB] = r.polled;
        rv[ST_WQ_LSB +: QSEL_W] = r.wq;
      end
      ADDR_LEVEL:  rv[CNT_W-1:0] = level_q[r.wq];
      default:     rv = '0;
    endcase
    if (araddr == ADDR_CONFIG) begin
      rv[CFG_WMODE_LSB +: 2] = r.wmode;
    end
    if (arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rv;
      next_r.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    // a queue load and a bus strobe together carry conflicting address fields
    if (write_queue_load) begin
      next_r.wq = write_address_bus[QSEL_W-1:0];
    end
    // flag bus ownership
    next_r.started = 1'b1;
    next_r.sync_p = 1'b0;
    if (r.polled) begin
      next_r.own = (!r.started && r.master) || token_in;
      next_r.sync_p = !r.started && r.master;
    end else if (flag_bus_select_strobe) begin
      // new selection every cycle is allowed, alongside queue writes
      next_r.own = (write_address_bus[WADDR_W-1 -: DEV_ID_W] == r.dev_id);
    end
    next_r.tok_o = r.polled && next_r.own;
    for (int i = 0; i < NUM_Q; i++) begin
      // bits of unconfigured queues are parked high
      next_r.status[i] = !af_set_q[i] || (NQ_W'(i) >= r.nq);
    end
    // discrete flags use the new selection so they never lag a switch
    next_r.af_n = !af_set_q[next_r.wq];
    next_r.ff_n = !full_next_q[next_r.wq];
    if (!aresetn) begin
      next_r = '0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
      next_r.arready = 1'b1;
      next_r.wmode = WIDTH_EQUAL;
      next_r.nq = NQ_RESET;
      next_r.depth = DEPTH_RESET;
      next_r.status = '1;
      next_r.af_n = 1'b1;
      next_r.ff_n = 1'b1;
      next_r.polled = straps_s[2];
      next_r.master = straps_s[1];
      next_r.df = straps_s[0];
      next_r.dev_id = dev_id_s;
    end
  end

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign almost_full_flag_n = r.af_n;
  assign full_flag_n = r.ff_n;
  assign almost_full_status_bus_o = r.status;
  assign almost_full_status_bus_oe = r.own;
  assign flag_bus_sync_pulse = r.sync_p;
  assign token_out = r.tok_o;

  a_bus_assert_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(raw_q[0]) ##1 raw_q[0] && r.nq != '0) |=> !almost_full_status_bus_o[0])
    else $error("bus bit 0 not low two edges after boundary write");

  a_bus_release_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(raw_q[0]) && r.nq != '0) |=> almost_full_status_bus_o[0])
    else $error("bus bit 0 not high one edge after leaving boundary");

  a_discrete_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(raw_q[r.wq]) ##1 (raw_q[r.wq] && $stable(r.wq))) |=> !almost_full_flag_n)
    else $error("discrete almost-full not low two edges after write");

  a_discrete_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (NQ_W'(r.wq) < r.nq) |-> (almost_full_flag_n == almost_full_status_bus_o[r.wq]))
    else $error("discrete flag disagrees with bus bit of active queue");

  a_direct_take: assert property (@(posedge aclk) disable iff (!aresetn)
    (!r.polled && flag_bus_select_strobe &&
     write_address_bus[WADDR_W-1 -: DEV_ID_W] == r.dev_id) |=> almost_full_status_bus_oe)
    else $error("matching strobe did not take the flag bus");

  a_direct_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (!r.polled && flag_bus_select_strobe &&
     write_address_bus[WADDR_W-1 -: DEV_ID_W] != r.dev_id) |=> !almost_full_status_bus_oe)
    else $error("bus still driven after another device selected");

  a_sync_once: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_bus_sync_pulse |-> token_out ##1 !flag_bus_sync_pulse [*8])
    else $error("sync pulse not a single owned cycle");

  a_token_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.polled && token_in) |=> (almost_full_status_bus_oe && token_out))
    else $error("token in did not hand over the bus");

  a_offset_default: assert property (@(posedge aclk) disable iff (!aresetn)
    !r.off_prog |-> (off_eff == (straps_s[0] ? OFFSET_DEF_HI : OFFSET_DEF_LO)))
    else $error("default almost-full offset wrong");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before bready");

  c_direct_take: cover property (@(posedge aclk) disable iff (!aresetn)
    !r.polled && $rose(almost_full_status_bus_oe));
  c_polled_token: cover property (@(posedge aclk) disable iff (!aresetn)
    r.polled && token_in ##1 token_out);
  c_af_low: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(almost_full_flag_n));
  c_af_release: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(almost_full_status_bus_o[0]));
endmodule : almost_full_flag_bus

/* tb/wr_ctrl_model.sv */
// write-port controller model: queue writes, reads and flag-bus selection
`timescale 1ns/1ps
module wr_ctrl_model
  import af_flag_pkg::*;
(
  input  wire logic               aclk,
  output logic                    write_enable,
  output logic                    write_queue_load,
  output logic      [WADDR_W-1:0] write_address_bus,
  output logic                    flag_bus_select_strobe,
  output logic                    read_enable,
  output logic      [QSEL_W-1:0]  read_queue
);
  initial begin
    write_enable           = 1'b0;
    write_queue_load       = 1'b0;
    write_address_bus      = 5'h15;
    flag_bus_select_strobe = 1'b0;
    read_enable            = 1'b0;
    read_queue             = 2'h3;
  end
  // every task starts and returns just after a rising edge
  task automatic put_words(input int n);
    write_enable <= 1'b1;
    repeat (n) @(posedge aclk);
    write_enable <= 1'b0;
  endtask : put_words
  task automatic take_word();
    read_enable <= 1'b1;
    @(posedge aclk);
    read_enable <= 1'b0;
  endtask : take_word
  task automatic set_read_queue(input logic [QSEL_W-1:0] q);
    read_queue <= q;
  endtask : set_read_queue
  // load and selection live in separate tasks; they share a cycle only when load_queue follows select_device with keep set
  task automatic load_queue(input logic [QSEL_W-1:0] q);
    write_queue_load  <= 1'b1;
    write_address_bus <= {3'h5, q};
    @(posedge aclk);
    write_queue_load  <= 1'b0;
    write_address_bus <= {3'h2, ~q};
  endtask : load_queue
  // keep leaves the strobe up so selections can follow every cycle
  task automatic select_device(input logic [DEV_ID_W-1:0] id, input bit keep);
    flag_bus_select_strobe <= 1'b1;
    write_address_bus      <= {id, 2'h1};
    @(posedge aclk);
    if (!keep) begin
      flag_bus_select_strobe <= 1'b0;
      write_address_bus      <= {~id, 2'h2};
    end
  endtask : select_device
endmodule : wr_ctrl_model

/* tb/almost_full_flag_bus_bench.sv */
// self-checking bench for the almost-full flag bus block
`timescale 1ns/1ps
module almost_full_flag_bus_bench;
  import af_flag_pkg::*;
  typedef struct {int t; logic [31:0] e; logic [31:0] m;} note_s;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0, token_in = 1'b0;
  logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
  logic [31:0]         wdata = '0;
  logic [2:0]          awprot = '0, arprot = '0;
  logic [3:0]          wstrb = 4'hF;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata, probe, rng;
  logic                write_enable, write_queue_load, flag_bus_select_strobe, read_enable;
  logic [WADDR_W-1:0]  write_address_bus;
  logic [QSEL_W-1:0]   read_queue;
  logic [DEV_ID_W-1:0] device_number_inputs, other_id;
  logic                flag_bus_mode_select = 1'b0, ring_master_select = 1'b0;
  logic                default_offset_select = 1'b0;
  logic                almost_full_flag_n, full_flag_n, almost_full_status_bus_oe;
  logic                flag_bus_sync_pulse, token_out;
  logic [NUM_Q-1:0]    almost_full_status_bus_o;
  note_s               notes[$], pq[$];
  int                  failures = 0, n_compared = 0, cyc = 0;

  always #2.5 aclk = ~aclk;
  assign probe = {23'h0, full_flag_n, token_out, flag_bus_sync_pulse,
                  almost_full_status_bus_oe, almost_full_flag_n, almost_full_status_bus_o};

  almost_full_flag_bus almost_full_flag_bus_i (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .write_enable, .write_queue_load, .write_address_bus,
    .flag_bus_select_strobe, .read_enable, .read_queue, .device_number_inputs,
    .flag_bus_mode_select, .ring_master_select, .default_offset_select, .token_in,
    .almost_full_flag_n, .full_flag_n, .almost_full_status_bus_o, .almost_full_status_bus_oe,
    .flag_bus_sync_pulse, .token_out
  );
  wr_ctrl_model wr_ctrl_model_i (
    .aclk, .write_enable, .write_queue_load, .write_address_bus, .flag_bus_select_strobe,
    .read_enable, .read_queue
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] act, input logic [31:0] e, input logic [31:0] m);
    n_compared++;
    if ((act & m) !== (e & m)) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, act & m, e & m);
    end
  endtask : check

  task automatic take(input logic [31:0] act);
    note_s n;
    if (notes.size() == 0) begin
      check(act, ~act, '1);
      return;
    end
    n = notes.pop_front();
    check(act, n.e, n.m);
  endtask : take

  // probe notes carry the cycle they belong to; bus answers pair in order
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    while (pq.size() > 0 && pq[0].t <= cyc) begin
      check(probe, pq[0].e, pq[0].m);
      void'(pq.pop_front());
    end
    if (bvalid && bready) take({30'h0, bresp});
    if (rvalid && rready) begin
      take(rdata);
      take({30'h0, rresp});
    end
  end

  task automatic look(input logic [31:0] e, input logic [31:0] m);
    pq.push_back('{cyc + 1, e, m});
    @(posedge aclk);
  endtask : look

  task automatic steps(input logic [31:0] pre, input logic [31:0] post, input logic [31:0] m,
                       input int n);
    repeat (n) look(pre, m);
    look(post, m);
  endtask : steps

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back('{0, {30'h0, r}, 32'h3});
    rng     = xs(rng);
    awaddr  <= a;
    awprot  <= rng[2:0];
    // top byte lies above every field, so its strobe may vary freely
    wstrb   <= {rng[3], 3'h7};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) return;
    end
    check(32'h0, 32'h1, 32'h1);
    test_done();
  endtask : axi_wr

  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back('{0, d, 32'hFFFF_FFFF});
    notes.push_back('{0, {30'h0, r}, 32'h3});
    rng     = xs(rng);
    araddr  <= a;
    arprot  <= rng[2:0];
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) return;
    end
    check(32'h0, 32'h1, 32'h1);
    test_done();
  endtask : axi_rd

  // three low edges: two to pass the strap synchronisers, one to capture
  task automatic do_reset(input logic fm, input logic ms, input logic df);
    aresetn               <= 1'b0;
    flag_bus_mode_select  <= fm;
    ring_master_select    <= ms;
    default_offset_select <= df;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial begin
    rng = xs(32'hD476);
    device_number_inputs = rng[2:0];
    rng = xs(rng);
    other_id = device_number_inputs ^ (rng[2:0] | 3'h1);
    do_reset(1'b0, 1'b0, 1'b0);
    look(32'h11F, 32'h1FF);
    axi_rd(ADDR_OFFSET, 32'h8, RESP_OKAY);
    axi_rd(ADDR_DEPTH, 32'h4000, RESP_OKAY);
    axi_rd(ADDR_CONFIG, 32'h40, RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    axi_wr(ADDR_DEPTH, 32'h10, RESP_OKAY);
    $display("test registers done");
    wr_ctrl_model_i.select_device(device_number_inputs, 1);
    fork
      wr_ctrl_model_i.select_device(other_id, 0);
      look(32'h20, 32'h20);
    join
    look(32'h0, 32'h20);
    wr_ctrl_model_i.select_device(device_number_inputs, 0);
    @(posedge aclk);
    wr_ctrl_model_i.load_queue(2'h0);
    wr_ctrl_model_i.put_words(7);
    look(32'h3F, 32'h3F);
    wr_ctrl_model_i.put_words(1);
    steps(32'h3F, 32'h2E, 32'h3F, 2);
    wr_ctrl_model_i.set_read_queue(2'h0);
    wr_ctrl_model_i.take_word();
    steps(32'h2E, 32'h3F, 32'h3F, 1);
    wr_ctrl_model_i.put_words(1);
    steps(32'h3F, 32'h2E, 32'h3F, 2);
    wr_ctrl_model_i.set_read_queue(2'h1);
    wr_ctrl_model_i.load_queue(2'h1);
    look(32'h3E, 32'h3F);
    wr_ctrl_model_i.put_words(8);
    look(32'h3E, 32'h3F);
    wr_ctrl_model_i.put_words(1);
    steps(32'h3E, 32'h2C, 32'h3F, 2);
    wr_ctrl_model_i.put_words(8);
    look(32'h02C, 32'h1FF);
    axi_rd(ADDR_LEVEL, 32'h11, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h14C, RESP_OKAY);
    $display("test direct mode done");
    do_reset(1'b1, 1'b1, 1'b1);
    steps(32'h0, 32'hE0, 32'hE0, 1);
    look(32'h0, 32'hE0);
    token_in <= 1'b1;
    @(posedge aclk);
    token_in <= 1'b0;
    look(32'hA0, 32'hE0);
    wr_ctrl_model_i.select_device(device_number_inputs, 0);
    look(32'h0, 32'h20);
    axi_rd(ADDR_OFFSET, 32'h80, RESP_OKAY);
    axi_wr(ADDR_DEPTH, 32'h10, RESP_OKAY);
    axi_wr(ADDR_OFFSET, 32'h4, RESP_OKAY);
    axi_wr(ADDR_CONFIG, 32'h41, RESP_OKAY);
    wr_ctrl_model_i.set_read_queue(2'h2);
    wr_ctrl_model_i.load_queue(2'h2);
    wr_ctrl_model_i.put_words(11);
    look(32'h10, 32'h10);
    wr_ctrl_model_i.put_words(1);
    steps(32'h10, 32'h0, 32'h10, 2);
    axi_wr(ADDR_CONFIG, 32'h42, RESP_OKAY);
    wr_ctrl_model_i.set_read_queue(2'h3);
    wr_ctrl_model_i.load_queue(2'h3);
    wr_ctrl_model_i.put_words(25);
    look(32'h10, 32'h10);
    wr_ctrl_model_i.put_words(1);
    steps(32'h10, 32'h0, 32'h10, 2);
    $display("test polled mode and widths done");
    test_done();
  end
endmodule : almost_full_flag_bus_bench
